// ### inc/alarm_status_flags_consts.svh
/*
  Constants of the alarm status flag block: register indices, field positions and reset values.
  Assumes an Avalon-MM slave with 32-bit words, one register per aligned word.
*/
`ifndef ALARM_STATUS_FLAGS_CONSTS_SVH
`define ALARM_STATUS_FLAGS_CONSTS_SVH

// ==========================================================================
// Register indices; byte address is four times the index.
`define IDX_COMBINED_ALARM 10'h2C0
`define IDX_ALARM_STATUS 10'h2C1
`define IDX_ALARM_MASK 10'h2C2
`define IDX_LANE_RECORD 10'h2C4
`define IDX_LINK_CONTROL 10'h2C8

// ==========================================================================
// Field positions and reset values.
`define BIT_FIFO 5
`define BIT_PLL 4
`define BIT_LINK 3
`define BIT_REALIGN 2
`define BIT_DIVIDER 0
`define STATUS_RESET 8'h3F
`define MASK_RESET 8'h3F
`define RECORD_RESET 8'hFF
`define CONTROL_RESET 8'h00

`endif

// ### inc/alarm_status_flags_pkg.sv
/*
  Types shared by the alarm status flag block.
  Assumes the constants header is included alongside.
*/
package alarm_status_flags_pkg;
  typedef enum logic [1:0] {bus_idle, bus_answer} bus_state_t;
endpackage

// ### rtl/sticky_flag.sv
/*
  One sticky write-one-to-clear flag with a reset value.
  Assumes set and clear are synchronous to the clock.
*/
`timescale 1ns/100ps
module sticky_flag #(
  parameter logic RESET_VALUE = 1'b1
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic set_i,
  input wire logic clear_i,
  output logic flag_o
);
  // ==========================================================================
  // Flag storage.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_o <= RESET_VALUE;
    end else if (set_i) begin
      flag_o <= 1'b1;
    end else if (clear_i) begin
      flag_o <= 1'b0;
    end
  end
endmodule

// ### rtl/alarm_status_flags.sv
/*
  Alarm status flags with mask, combined alarm and per-lane FIFO record, on Avalon-MM.
  Assumes hardware condition inputs are synchronous to ref_clk_i.
*/
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/100ps
`include "alarm_status_flags_consts.svh"
module alarm_status_flags #(
  parameter int LANES = 8
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic soft_reset_i,
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [1:0] avs_response_o,
  input wire logic [LANES-1:0] lane_active_i,
  input wire logic [LANES-1:0] lane_fifo_error_i,
  input wire logic serdes_pll_locked_i,
  input wire logic link_mode_64b66b_i,
  input wire logic data_encode_state_i,
  input wire logic link_start_i,
  input wire logic serializer_realign_i,
  input wire logic sysref_realign_i,
  input wire logic [3:0] divider_ab_i,
  input wire logic [3:0] divider_cd_i,
  output logic link_enable_o,
  output logic combined_alarm_o
);
  // ==========================================================================
  // Reset release.
  logic [1:0] rst_sync;
  logic rst_n;
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ==========================================================================
  // Bus access. Every request answers one cycle after it is seen.
  alarm_status_flags_pkg::bus_state_t bus_state;
  logic [9:0] index;
  logic wr_take;
  logic rd_take;
  logic lane0_wr;
  logic [7:0] wdata;
  assign index = avs_address_i[11:2];
  assign wdata = avs_byteenable_i[0] ? avs_writedata_i[7:0] : 8'h00;
  assign lane0_wr = avs_byteenable_i[0];
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) &&
                             (bus_state == alarm_status_flags_pkg::bus_idle);
  assign wr_take = avs_write_i && (bus_state == alarm_status_flags_pkg::bus_answer);
  assign rd_take = avs_read_i && (bus_state == alarm_status_flags_pkg::bus_answer);

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bus_state <= alarm_status_flags_pkg::bus_idle;
    end else begin
      unique case (bus_state)
        alarm_status_flags_pkg::bus_idle: begin
          if (avs_read_i | avs_write_i) begin
            bus_state <= alarm_status_flags_pkg::bus_answer;
          end
        end
        alarm_status_flags_pkg::bus_answer: begin
          bus_state <= alarm_status_flags_pkg::bus_idle;
        end
      endcase
    end
  end

  // ==========================================================================
  // Mask and link control registers.
  logic [7:0] alarm_mask_bits;
  logic link_enable;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      alarm_mask_bits <= `MASK_RESET;
    end else if (soft_reset_i) begin
      alarm_mask_bits <= `MASK_RESET;
    end else if (wr_take && lane0_wr && index == `IDX_ALARM_MASK) begin
      alarm_mask_bits <= wdata;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      link_enable <= 1'b0;
    end else if (soft_reset_i) begin
      link_enable <= 1'b0;
    end else if (wr_take && lane0_wr && index == `IDX_LINK_CONTROL) begin
      link_enable <= wdata[0];
    end
  end
  assign link_enable_o = link_enable;

  // ==========================================================================
  // Set conditions. While the link is off these flags carry no meaning, so
  // their sources are not qualified further than the rules ask.
  logic status_wr;
  logic [7:0] set_cond;
  logic [7:0] clr_cond;
  logic [LANES-1:0] lane_hit;
  logic link_was_enabled;
  logic link_rise;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      link_was_enabled <= 1'b0;
    end else begin
      link_was_enabled <= link_enable;
    end
  end
  assign link_rise = link_enable & ~link_was_enabled;
  assign lane_hit = lane_active_i & lane_fifo_error_i;
  assign status_wr = wr_take && lane0_wr && (index == `IDX_ALARM_STATUS);

  always_comb begin
    set_cond = 8'h00;
    set_cond[`BIT_FIFO] = |lane_hit;
    set_cond[`BIT_PLL] = ~serdes_pll_locked_i;
    if (link_mode_64b66b_i) begin
      set_cond[`BIT_LINK] = link_rise | link_start_i | serializer_realign_i;
    end else begin
      set_cond[`BIT_LINK] = link_enable & ~data_encode_state_i;
    end
    set_cond[`BIT_REALIGN] = sysref_realign_i;
    set_cond[`BIT_DIVIDER] = divider_ab_i != divider_cd_i;
    // Soft reset forces every flag back to one.
    if (soft_reset_i) begin
      set_cond[5:0] = 6'h3F;
    end
    clr_cond = status_wr ? wdata : 8'h00;
  end

  // ==========================================================================
  // Status flags: bits 5..0 are sticky, bits 7:6 read zero.
  localparam logic [7:0] status_reset = `STATUS_RESET;
  logic [7:0] alarm_status_flags;
  assign alarm_status_flags[7:6] = 2'b00;
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : gen_flag
      sticky_flag #(
        .RESET_VALUE(status_reset[g])
      ) u_flag (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n),
        .set_i(set_cond[g]),
        .clear_i(clr_cond[g]),
        .flag_o(alarm_status_flags[g])
      );
    end
  endgenerate

  // ==========================================================================
  // Per-lane FIFO fault record.
  logic [LANES-1:0] per_lane_fifo_fault_record;
  logic rec_wr;
  assign rec_wr = wr_take && lane0_wr && (index == `IDX_LANE_RECORD);
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      per_lane_fifo_fault_record <= {LANES{1'b1}};
    end else if (soft_reset_i) begin
      per_lane_fifo_fault_record <= {LANES{1'b1}};
    end else begin
      for (int i = 0; i < LANES; i++) begin
        if (lane_hit[i]) begin
          per_lane_fifo_fault_record[i] <= 1'b1;
        end else if (clr_cond[`BIT_FIFO]) begin
          per_lane_fifo_fault_record[i] <= 1'b0;
        end else if (rec_wr && i < 8 && wdata[i % 8]) begin
          per_lane_fifo_fault_record[i] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // Combined alarm.
  assign combined_alarm_o = |(alarm_status_flags & ~alarm_mask_bits);

  // ==========================================================================
  // Read data register and response.
  logic [7:0] rd_mux;
  logic rd_ok;
  always_comb begin
    rd_mux = 8'h00;
    rd_ok = 1'b1;
    unique case (index)
      `IDX_COMBINED_ALARM: rd_mux = {7'h00, combined_alarm_o};
      `IDX_ALARM_STATUS: rd_mux = alarm_status_flags;
      `IDX_ALARM_MASK: rd_mux = alarm_mask_bits;
      `IDX_LANE_RECORD: rd_mux = 8'(per_lane_fifo_fault_record);
      `IDX_LINK_CONTROL: rd_mux = {7'h00, link_enable};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata_o <= 32'h0000_0000;
      avs_response_o <= 2'b00;
    end else if ((bus_state == alarm_status_flags_pkg::bus_idle) &&
                 (avs_read_i || avs_write_i)) begin
      // Loading only on a new request keeps the last answer standing between accesses.
      avs_readdata_o <= {24'h00_0000, avs_read_i ? rd_mux : 8'h00};
      avs_response_o <= rd_ok ? 2'b00 : 2'b11;
    end
  end
endmodule

// ### verif/alarm_status_flags_monitor.sv
/*
  Port checker for the alarm status flag block.
  Assumes it is bound to the block's top module and sees its ports only.
*/
`timescale 1ns/100ps
`include "alarm_status_flags_consts.svh"
// ==========================================================================
// Checker.
module alarm_status_flags_monitor (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic soft_reset_i,
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [1:0] avs_response_o,
  input wire logic serdes_pll_locked_i,
  input wire logic sysref_realign_i,
  input wire logic [3:0] divider_ab_i,
  input wire logic [3:0] divider_cd_i,
  input wire logic combined_alarm_o
);
  logic req;
  logic rdv;
  assign req = avs_read_i | avs_write_i;
  assign rdv = avs_read_i & !avs_waitrequest_o & (avs_address_i[11:2] == `IDX_ALARM_STATUS);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Flags are checked two edges back: one edge to register the flag, one because read data load one edge early.
  a_wait_first: assert property (req && !$past(req) |-> avs_waitrequest_o)
    else $error("waitrequest low in first request cycle");
  a_wait_second: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest held past one wait cycle");
  a_upper_zero: assert property (avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_resp_bad: assert property (req && !avs_waitrequest_o && avs_address_i[11:2] == 10'h2C3
    |-> avs_response_o == 2'b11) else $error("unmapped access not refused");
  a_resp_good: assert property (req && !avs_waitrequest_o && avs_address_i[11:2] == `IDX_ALARM_STATUS
    |-> avs_response_o == 2'b00) else $error("mapped access refused");
  a_pll_flag: assert property (
    rdv && !$past(serdes_pll_locked_i, 2) |-> avs_readdata_o[`BIT_PLL])
    else $error("unlock flag not set");
  a_divider_flag: assert property (
    rdv && $past(divider_ab_i, 2) != $past(divider_cd_i, 2) |-> avs_readdata_o[`BIT_DIVIDER])
    else $error("divider flag not set");
  a_realign_flag: assert property (
    rdv && $past(sysref_realign_i, 2) |-> avs_readdata_o[`BIT_REALIGN])
    else $error("realign flag not set");
  a_soft_mask: assert property (soft_reset_i |=> !combined_alarm_o)
    else $error("combined alarm high after soft reset");
  a_read_stable: assert property (!(req && avs_waitrequest_o) |=> $stable(avs_readdata_o))
    else $error("read data changed without a request");
endmodule
bind alarm_status_flags alarm_status_flags_monitor i_mon (
  .ref_clk_i(ref_clk_i),
  .reset_n_i(reset_n_i),
  .soft_reset_i(soft_reset_i),
  .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o),
  .avs_response_o(avs_response_o),
  .serdes_pll_locked_i(serdes_pll_locked_i),
  .sysref_realign_i(sysref_realign_i),
  .divider_ab_i(divider_ab_i),
  .divider_cd_i(divider_cd_i),
  .combined_alarm_o(combined_alarm_o)
);

// ### verif/alarm_status_flags_test.sv
/*
  Self-checking bench for the alarm status flag block.
  Assumes one wait cycle per access; hardware conditions are held as levels.
*/
`timescale 1ns/100ps
`include "alarm_status_flags_consts.svh"
// ==========================================================================
// Bench top.
module alarm_status_flags_test;
  localparam logic [9:0] ST = `IDX_ALARM_STATUS;
  localparam logic [9:0] MK = `IDX_ALARM_MASK;
  localparam logic [9:0] RC = `IDX_LANE_RECORD;
  int bits[7] = '{`BIT_FIFO, `BIT_PLL, `BIT_LINK, `BIT_REALIGN, `BIT_DIVIDER, `BIT_LINK, `BIT_LINK};
  logic clk = 1'b0, rst_n = 1'b0, sr = 1'b0, rd = 1'b0, wr = 1'b0;
  logic lock = 1'b1, m64 = 1'b0, enc = 1'b1, ls = 1'b0, srl = 1'b0, sys = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic [1:0] resp, rs;
  logic [7:0] lf = 8'h00;
  logic [7:0] la = 8'hFF;
  logic [7:0] q;
  logic [3:0] dcd = 4'h5;
  logic wq, comb, le;
  int miscompares = 0;
  int tests_run = 0;
  always #20 clk = ~clk;
  alarm_status_flags i_dut (
    .ref_clk_i(clk), .reset_n_i(rst_n), .soft_reset_i(sr), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wq), .avs_response_o(resp),
    .lane_active_i(la), .lane_fifo_error_i(lf), .serdes_pll_locked_i(lock),
    .link_mode_64b66b_i(m64), .data_encode_state_i(enc), .link_start_i(ls),
    .serializer_realign_i(srl), .sysref_realign_i(sys), .divider_ab_i(4'h5),
    .divider_cd_i(dcd), .link_enable_o(le), .combined_alarm_o(comb)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("Mismatches %0d of %0d comparisons", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // One idle edge first, so a request never rises in the edge that drops the last.
  task automatic acc(input logic w, input logic [9:0] i, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= {i, 2'b00};
    wd <= {24'h0, d};
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clk);
      n++;
    end while (wq !== 1'b0 && n < 20);
    if (n >= 20) begin
      miscompares++;
      test_done;
    end else begin
      q = rdata[7:0];
      rs = resp;
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask
  task automatic trg(input int k);
    case (k)
      0: lf <= 8'h08;
      1: lock <= 1'b0;
      2: enc <= 1'b0;
      3: sys <= 1'b1;
      4: dcd <= 4'h6;
      5: ls <= 1'b1;
      default: srl <= 1'b1;
    endcase
    m64 <= (k > 4);
  endtask
  task automatic idle;
    lf <= 8'h00;
    lock <= 1'b1;
    enc <= 1'b1;
    sys <= 1'b0;
    dcd <= 4'h5;
    ls <= 1'b0;
    srl <= 1'b0;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    acc(0, ST, 8'h00);
    chk(q, `STATUS_RESET);
    acc(0, MK, 8'h00);
    chk(q, `MASK_RESET);
    acc(0, RC, 8'h00);
    chk(q, `RECORD_RESET);
    chk(comb, 1'b0);
    acc(1, `IDX_LINK_CONTROL, 8'h01);
    acc(1, ST, 8'hFF);
    acc(0, `IDX_LINK_CONTROL, 8'h00);
    chk(q, 8'h01);
    chk(le, 1'b1);
    for (int k = 0; k < 7; k++) begin
      trg(k);
      acc(1, ST, 8'h00);
      acc(0, ST, 8'h00);
      chk(q & 8'h3D, 8'h01 << bits[k]);
      idle;
      acc(1, ST, 8'h01 << bits[k]);
      acc(0, ST, 8'h00);
      chk(q & 8'h3D, 8'h00);
    end
    lock <= 1'b0;
    acc(1, MK, 8'h2F);
    acc(1, ST, 8'h10);
    acc(0, ST, 8'h00);
    chk(q[4], 1'b1);
    chk(comb, 1'b1);
    acc(0, `IDX_COMBINED_ALARM, 8'h00);
    chk(q, 8'h01);
    lock <= 1'b1;
    acc(1, ST, 8'h10);
    @(posedge clk);
    chk(comb, 1'b0);
    trg(1);
    acc(1, MK, 8'h3F);
    @(posedge clk);
    chk(comb, 1'b0);
    trg(0);
    acc(0, RC, 8'h00);
    chk(q, 8'h08);
    idle;
    acc(1, ST, 8'h20);
    acc(0, RC, 8'h00);
    chk(q, 8'h00);
    la <= 8'hF7;
    lf <= 8'h08;
    acc(0, ST, 8'h00);
    chk(q[5], 1'b0);
    la <= 8'hFF;
    lf <= 8'h00;
    acc(0, 10'h2C3, 8'h00);
    chk(rs, 2'h3);
    chk(q, 8'h00);
    sr <= 1'b1;
    @(posedge clk);
    sr <= 1'b0;
    acc(0, ST, 8'h00);
    chk(q, `STATUS_RESET);
    acc(0, MK, 8'h00);
    chk(q, `MASK_RESET);
    test_done;
  end
endmodule
